// File: src/sbpc_map.vh
// sbpc_map.vh: constants for the serial bitstream programming controller
// assumes inclusion by the design and bench files of this block only
// Contract
// - serial pins shared by controller and user logic
// - mode pin picks master or slave role
// - enable pin tri-states mosi, miso, ss, clk
// - auto update: newer flash image programs device
// - auto program: blank device loads flash image
// - interrupted update recovers from golden image
// - suspend bit holds controller in triple latch
// - suspend shown to user; reset holds idle so no fetch starts, a load already under way runs on
`ifndef SBPC_MAP_VH
`define SBPC_MAP_VH
// loader state codes
`define SBPC_ST_IDLE 3'h0
`define SBPC_ST_CHECK 3'h1
`define SBPC_ST_LOAD 3'h2
`define SBPC_ST_DONE 3'h3
`define SBPC_ST_SLAVE 3'h4
// image select codes
`define SBPC_IMG_NEW 2'h0
`define SBPC_IMG_FIRST 2'h1
`define SBPC_IMG_GOLDEN 2'h2
// settle time after power-up before the flash check, ns
`define SBPC_SETTLE_NS 100
`define SBPC_CLK_NS 5
`define SBPC_SETTLE_CYC ((`SBPC_SETTLE_NS + `SBPC_CLK_NS - 1) / `SBPC_CLK_NS)
// serial clock divider, system cycles per half period
`define SBPC_SCK_HALF 4'h4
`endif

// File: src/sbpc_sync.v
// sbpc_sync.v: two flip-flop level synchroniser, parameterised width
// assumes the input is asynchronous to i_clk_sys
`timescale 1ns/1ps
module sbpc_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rstn,
  // levels
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_ff; // first stage, read only by the second
  reg [W-1:0] sync_ff; // second stage

  // plain two-stage capture
  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// File: src/sbpc_top.v
// sbpc_top.v: power-up loader and serial pin arbiter for programming
// assumes i_rstn is the power-up reset; pins arrive asynchronous
`timescale 1ns/1ps
`include "sbpc_map.vh"
module sbpc_top #(
  parameter SETTLE = `SBPC_SETTLE_CYC,
  parameter IMG_BYTES = 16
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rstn,
  // strap and mode pins
  input wire i_mode_master,
  input wire i_port_enable_n,
  input wire i_auto_update,
  input wire i_auto_program,
  input wire i_device_blank,
  input wire i_update_aborted,
  input wire i_suspend_bit,
  input wire i_jtag_trst_n,
  // flash status from serial link
  input wire i_flash_newer,
  input wire i_flash_present,
  // serial pins, split into in, out, enable
  input wire i_sck,
  output wire o_sck,
  output wire o_sck_oe,
  input wire i_ss_n,
  output wire o_ss_n,
  output wire o_ss_n_oe,
  input wire i_mosi,
  output wire o_mosi,
  output wire o_mosi_oe,
  input wire i_miso,
  output wire o_miso,
  output wire o_miso_oe,
  // user serial port macro
  input wire i_usr_sck,
  input wire i_usr_ss_n,
  input wire i_usr_mosi,
  input wire i_usr_oe,
  output wire o_usr_miso,
  output wire o_usr_grant,
  // status
  output wire o_busy,
  output wire o_done,
  output wire [1:0] o_image,
  output wire o_suspend,
  output wire o_ctrl_reset,
  output wire o_slave_rx_bit,
  output wire o_slave_rx_vld
);
  // last bit index of a load, cut to the counter width on purpose
  localparam [31:0] LAST_BIT32 = IMG_BYTES * 8 - 1;
  localparam [15:0] LAST_BIT = LAST_BIT32[15:0];
  wire mode_m, en_n, auto_up, auto_pr, blank, aborted, susp_b, trst_n, newer, present;
  wire sck_s, ss_s, mosi_s, miso_s;
  reg [2:0] st_ff, nxt_st;
  reg [1:0] img_ff, nxt_img;
  reg [15:0] cnt_ff, nxt_cnt;
  reg [2:0] susp_ff; // triple redundant latch copies
  reg sck_ff, sck_d_ff, rx_bit_ff, rx_vld_ff, miso_ff;
  reg [3:0] div_ff;
  wire susp_vote;
  wire sck_rise;

  // all asynchronous pins through two flops
  sbpc_sync #(.W(14)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async({i_mode_master, i_port_enable_n, i_auto_update, i_auto_program, i_device_blank,
      i_update_aborted, i_suspend_bit, i_jtag_trst_n, i_flash_newer, i_flash_present,
      i_sck, i_ss_n, i_mosi, i_miso}),
    .o_sync({mode_m, en_n, auto_up, auto_pr, blank, aborted, susp_b, trst_n, newer, present,
      sck_s, ss_s, mosi_s, miso_s})
  );
  // majority of three latch copies
  function vote3;
    input [2:0] v;
    begin
      vote3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    end
  endfunction
  assign susp_vote = vote3(susp_ff);

  // suspend latch: set from nonvolatile bit, released only when trst rises
  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      susp_ff <= 3'h0;
    else if (susp_b && !trst_n)
      susp_ff <= 3'h7;
    else if (trst_n)
      susp_ff <= 3'h0;
    else
      susp_ff <= {3{susp_vote}}; // scrub any single upset
  end
  assign o_suspend = susp_vote;
  assign o_ctrl_reset = susp_vote;

  // loader state machine
  always @*
  begin
    nxt_st = st_ff;
    nxt_img = img_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      `SBPC_ST_IDLE:
      begin
        // wait out settle time; held while suspended so no fetch occurs
        if (susp_vote)
          nxt_cnt = 16'h0000;
        else if (cnt_ff < SETTLE[15:0])
          nxt_cnt = cnt_ff + 16'h0001;
        else if (!mode_m)
          nxt_st = `SBPC_ST_SLAVE;
        else
        begin
          nxt_st = `SBPC_ST_CHECK;
          nxt_cnt = 16'h0000;
        end
      end
      `SBPC_ST_CHECK:
      begin
        // recovery outranks update, update outranks first load
        if (aborted && present)
        begin
          nxt_img = `SBPC_IMG_GOLDEN;
          nxt_st = `SBPC_ST_LOAD;
        end
        else if (auto_up && newer)
        begin
          nxt_img = `SBPC_IMG_NEW;
          nxt_st = `SBPC_ST_LOAD;
        end
        else if (auto_pr && blank && present)
        begin
          nxt_img = `SBPC_IMG_FIRST;
          nxt_st = `SBPC_ST_LOAD;
        end
        else
          nxt_st = `SBPC_ST_DONE;
      end
      `SBPC_ST_LOAD:
      begin
        // one byte per eight divided serial clocks
        if (en_n)
          nxt_st = `SBPC_ST_DONE;
        else if (div_ff == 4'h0 && sck_ff)
        begin
          if (cnt_ff == LAST_BIT)
            nxt_st = `SBPC_ST_DONE;
          else
            nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      `SBPC_ST_DONE:
        nxt_st = `SBPC_ST_DONE;
      `SBPC_ST_SLAVE:
        nxt_st = `SBPC_ST_SLAVE;
      default:
        nxt_st = `SBPC_ST_IDLE;
    endcase
  end

  // state registers
  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_ff <= `SBPC_ST_IDLE;
      img_ff <= `SBPC_IMG_NEW;
      cnt_ff <= 16'h0000;
    end
    else
    begin
      st_ff <= nxt_st;
      img_ff <= nxt_img;
      cnt_ff <= nxt_cnt;
    end
  end

  // master serial clock divider, runs only while loading
  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_ff <= 4'h0;
      sck_ff <= 1'b0;
    end
    else if (st_ff != `SBPC_ST_LOAD)
    begin
      div_ff <= 4'h0;
      sck_ff <= 1'b0;
    end
    else if (div_ff == `SBPC_SCK_HALF - 4'h1)
    begin
      div_ff <= 4'h0;
      sck_ff <= ~sck_ff;
    end
    else
      div_ff <= div_ff + 4'h1;
  end

  // slave receive: sample mosi on rising link clock edges
  assign sck_rise = sck_s & ~sck_d_ff;
  always @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sck_d_ff <= 1'b0;
      rx_bit_ff <= 1'b0;
      rx_vld_ff <= 1'b0;
      miso_ff <= 1'b0;
    end
    else
    begin
      sck_d_ff <= sck_s;
      rx_vld_ff <= (st_ff == `SBPC_ST_SLAVE) && !ss_s && sck_rise && !en_n;
      if (sck_rise)
        rx_bit_ff <= mosi_s;
      miso_ff <= miso_s;
    end
  end
  assign o_slave_rx_bit = rx_bit_ff;
  assign o_slave_rx_vld = rx_vld_ff;

  // controller busy while idle, checking or loading; user only when done
  assign o_busy = (st_ff == `SBPC_ST_CHECK) || (st_ff == `SBPC_ST_LOAD) || (st_ff == `SBPC_ST_IDLE);
  assign o_usr_grant = !o_busy && !en_n && (st_ff == `SBPC_ST_DONE);
  assign o_done = (st_ff == `SBPC_ST_DONE);
  assign o_image = img_ff;

  // pin drivers, all released while enable pin deasserted
  assign o_sck = o_usr_grant ? i_usr_sck : sck_ff;
  assign o_ss_n = o_usr_grant ? i_usr_ss_n : (st_ff != `SBPC_ST_LOAD);
  assign o_mosi = o_usr_grant ? i_usr_mosi : 1'b0;
  assign o_miso = rx_bit_ff;
  assign o_sck_oe = !en_n && ((st_ff == `SBPC_ST_LOAD) || (o_usr_grant && i_usr_oe));
  assign o_ss_n_oe = o_sck_oe;
  assign o_mosi_oe = o_sck_oe;
  assign o_miso_oe = !en_n && (st_ff == `SBPC_ST_SLAVE) && !ss_s;
  assign o_usr_miso = miso_ff;
endmodule

// File: testbench/sbpc_props.sv
// sbpc_props.sv: port checker for the loader
// assumes bind onto sbpc_top, map header on path
`timescale 1ns/1ps
`include "sbpc_map.vh"
module sbpc_props (
  input wire i_clk_sys, i_rstn, i_port_enable_n, i_mode_master,
  input wire i_suspend_bit, i_jtag_trst_n, i_update_aborted, i_flash_present,
  input wire o_sck_oe, o_ss_n_oe, o_mosi_oe, o_miso_oe, o_usr_grant,
  input wire o_busy, o_done, o_suspend, o_ctrl_reset, o_slave_rx_vld,
  input wire [1:0] o_image
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // levels held past the synchroniser
  sequence off_s; i_port_enable_n [*4]; endsequence
  sequence slv_s; !i_mode_master [*4]; endsequence
  sequence hold_s; (i_suspend_bit && !i_jtag_trst_n) [*5]; endsequence
  pins_tristate_a: assert property (off_s |-> !(o_sck_oe | o_ss_n_oe | o_mosi_oe | o_miso_oe))
    else $error("pin driven while released");
  slave_role_a: assert property (slv_s ##0 !o_usr_grant |-> !o_sck_oe && !o_ss_n_oe)
    else $error("slave drives clock");
  grant_idle_a: assert property (o_usr_grant |-> o_done && !o_busy)
    else $error("grant while busy");
  suspend_hold_a: assert property (hold_s |-> o_suspend && o_ctrl_reset)
    else $error("suspend not held");
  suspend_clear_a: assert property (i_jtag_trst_n [*5] |-> !o_suspend)
    else $error("suspend stuck");
  no_fetch_a: assert property (o_suspend && !o_done |=> !o_done)
    else $error("load while suspended");
  golden_img_a: assert property ($rose(o_done) && i_update_aborted && i_flash_present
    |-> o_image == `SBPC_IMG_GOLDEN)
    else $error("golden image not chosen");
  rx_pulse_a: assert property (o_slave_rx_vld |=> !o_slave_rx_vld)
    else $error("slave strobe too long");
endmodule
bind sbpc_top sbpc_props sbpc_props_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
  .i_port_enable_n(i_port_enable_n), .i_mode_master(i_mode_master), .i_suspend_bit(i_suspend_bit),
  .i_jtag_trst_n(i_jtag_trst_n), .i_update_aborted(i_update_aborted), .i_flash_present(i_flash_present),
  .o_sck_oe(o_sck_oe), .o_ss_n_oe(o_ss_n_oe), .o_mosi_oe(o_mosi_oe), .o_miso_oe(o_miso_oe),
  .o_usr_grant(o_usr_grant), .o_busy(o_busy), .o_done(o_done), .o_suspend(o_suspend),
  .o_ctrl_reset(o_ctrl_reset), .o_slave_rx_vld(o_slave_rx_vld), .o_image(o_image));

// File: testbench/sbpc_flash_model.sv
// sbpc_flash_model.sv: serial flash plus external master
// assumes the bench resolves pins from all enables
`timescale 1ns/1ps
module sbpc_flash_model (
  input wire i_sck,
  input wire i_ss_n,
  output reg o_miso,
  output reg o_sck,
  output reg o_ss_n,
  output reg o_mosi
);
  reg [7:0] img = 8'hC3; // flash image, rotated out
  initial {o_sck, o_ss_n, o_mosi, o_miso} = 4'h4;
  // flash answer, shifted on falling clock while selected
  always @(negedge i_sck)
    if (!i_ss_n)
      {o_miso, img} <= {img, img[7]};
  // deselected line shows no stale value
  always @(posedge i_ss_n)
    o_miso <= ~o_miso;
  // master frame, 125 ns clock, stands still outside
  task send(input [7:0] b);
    integer k;
    begin
      o_ss_n = 0;
      for (k = 7; k >= 0; k = k - 1)
      begin
        o_mosi = b[k];
        #62.5 o_sck = 1;
        #62.5 o_sck = 0;
      end
      o_ss_n = 1;
      o_mosi = ~b[0];
    end
  endtask
endmodule

// File: testbench/sbpc_top_tb.sv
// sbpc_top_tb.sv: self-checking bench for the loader
// assumes map header on path, short settle and image
`timescale 1ns/1ps
`include "sbpc_map.vh"
module sbpc_top_tb;
  reg clk = 0, rst_n = 0;
  reg [6:0] st = 0; // {mode, upd, prog, blank, abort, newer, present}
  reg en_n = 0, sbit = 0, trst_n = 1;
  reg [3:0] usr = 4'h4; // user macro pins
  reg [7:0] rx_b = 0; // bits seen by slave port
  integer error_cnt = 0, samples_checked = 0, rx_n = 0;
  wire sck, sck_oe, ss, ss_oe, mosi, mosi_oe, miso, miso_oe, ms, mss, mmo, mmi;
  wire grant, busy, done, susp, crst, rbit, rvld, usr_miso;
  wire [1:0] img;
  // wire level from whoever drives
  wire sck_w = sck_oe ? sck : ms;
  wire ss_w = ss_oe ? ss : mss;
  wire mosi_w = mosi_oe ? mosi : mmo;
  wire miso_w = miso_oe ? miso : mmi;
  initial forever #2.5 clk = ~clk;
  sbpc_top #(.SETTLE(2), .IMG_BYTES(1)) sbpc_top_i (.i_clk_sys(clk), .i_rstn(rst_n),
    .i_mode_master(st[6]), .i_auto_update(st[5]), .i_auto_program(st[4]), .i_device_blank(st[3]),
    .i_update_aborted(st[2]), .i_flash_newer(st[1]), .i_flash_present(st[0]), .i_port_enable_n(en_n),
    .i_suspend_bit(sbit), .i_jtag_trst_n(trst_n), .i_sck(sck_w), .o_sck(sck), .o_sck_oe(sck_oe),
    .i_ss_n(ss_w), .o_ss_n(ss), .o_ss_n_oe(ss_oe), .i_mosi(mosi_w), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
    .i_miso(miso_w), .o_miso(miso), .o_miso_oe(miso_oe), .i_usr_sck(usr[3]), .i_usr_ss_n(usr[2]),
    .i_usr_mosi(usr[1]), .i_usr_oe(usr[0]), .o_usr_miso(usr_miso), .o_usr_grant(grant), .o_busy(busy),
    .o_done(done), .o_image(img), .o_suspend(susp), .o_ctrl_reset(crst), .o_slave_rx_bit(rbit),
    .o_slave_rx_vld(rvld));
  sbpc_flash_model sbpc_flash_model_i (.i_sck(sck_w), .i_ss_n(ss_w), .o_miso(mmi), .o_sck(ms),
    .o_ss_n(mss), .o_mosi(mmo));
  // collect slave bits in arrival order
  always @(posedge clk)
    if (rvld === 1'b1)
    begin
      rx_b <= {rx_b[6:0], rbit};
      rx_n <= rx_n + 1;
    end
  task complete_run;
    begin
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // power-up with straps, reset held two cycles
  task pwr(input [6:0] s);
    begin
      @(posedge clk);
      rst_n <= 0;
      st <= s;
      repeat (2) @(posedge clk);
      rst_n <= 1;
    end
  endtask
  // bounded wait, a hang ends the run
  task wait_done;
    integer n;
    begin
      for (n = 0; n < 600 && done !== 1'b1; n = n + 1) @(posedge clk);
      if (n == 600)
      begin
        chk(0, 1);
        complete_run;
      end
    end
  endtask
  task t_image;
    begin
      pwr(7'h67); wait_done; chk(img, `SBPC_IMG_GOLDEN);
      pwr(7'h73); wait_done; chk(img, `SBPC_IMG_NEW);
      pwr(7'h59); wait_done; chk(img, `SBPC_IMG_FIRST);
      usr <= 4'hF;
      repeat (4) @(posedge clk);
      chk(grant, 1);
      chk({sck, ss, mosi, busy}, 8'h0E);
      chk(usr_miso, mmi);
    end
  endtask
  // release pins in mid-load
  task t_tri;
    begin
      pwr(7'h73);
      repeat (12) @(posedge clk);
      en_n <= 1;
      repeat (6) @(posedge clk);
      chk({done, sck_oe, ss_oe, mosi_oe, miso_oe}, 8'h10);
      en_n <= 0;
    end
  endtask
  task t_slave;
    integer n0;
    begin
      pwr(7'h00);
      repeat (20) @(posedge clk);
      n0 = rx_n;
      sbpc_flash_model_i.send(8'hA5);
      repeat (10) @(posedge clk);
      chk(rx_n - n0, 8);
      chk(miso, 1);
      chk(rx_b, 8'hA5);
    end
  endtask
  task t_susp;
    begin
      sbit <= 1;
      trst_n <= 0;
      pwr(7'h73);
      repeat (40) @(posedge clk);
      chk({susp, crst, done}, 8'h06);
      trst_n <= 1;
      repeat (10) @(posedge clk);
      chk(susp, 0);
      sbit <= 0;
    end
  endtask
  initial
  begin
    t_image;
    t_tri;
    t_slave;
    t_susp;
    complete_run;
  end
endmodule
